// >>> design/usart_rx_defs.svh
`ifndef USART_RX_DEFS_SVH
`define USART_RX_DEFS_SVH

// ----------------------------------------------------------------
// bit timing, in ticks of the 16x sample enable
// ----------------------------------------------------------------
`define RX_TICK_ONE      4'h1
`define RX_START_CNT     4'h1
`define RX_VOTE_FIRST    4'h8
`define RX_VOTE_LAST     4'hA

// ----------------------------------------------------------------
// character size codes and data bit counts
// ----------------------------------------------------------------
`define CSZ_NINE         3'h7
`define CSZ_LAST_SHORT   3'h3
`define RX_BITS_MIN      4'h5
`define RX_BITS_EIGHT    4'h8
`define RX_BITS_NINE     4'h9
`define RX_BITS_LAST     4'h1

// ----------------------------------------------------------------
// layout of one buffer entry
// ----------------------------------------------------------------
`define ENT_W            12
`define ENT_DATA_MSB     7
`define ENT_NINTH        8
`define ENT_FE           9
`define ENT_UPE          10
`define ENT_DOR          11

// ----------------------------------------------------------------
// line reset level and default sizes
// ----------------------------------------------------------------
`define RX_LINE_IDLE     1'b1
`define RX_FIFO_DEPTH    2
`define RX_DIV_W         12

`endif

// >>> design/usart_rx_pkg.sv
`include "usart_rx_defs.svh"

package usart_rx_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } rx_state_e;

  typedef struct packed {
    logic              rxd_meta;
    logic              rxd_sync;
    rx_state_e         state;
    logic [3:0]        tick_cnt;
    logic [2:0]        votes;
    logic [3:0]        bits_left;
    logic [8:0]        shreg;
    logic              par_acc;
    logic              par_err;
    logic              frame_pending;
    logic [`ENT_W-1:0] pend_entry;
    logic              lost;
    logic [7:0]        data_out;
    logic              ninth_out;
    logic              fe_out;
    logic              dor_out;
    logic              upe_out;
    logic              rxc_out;
    logic              irq_out;
    logic              override_out;
  } rx_top_s;

  function automatic logic majority3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // reserved size codes fall back to eight bits
  function automatic logic [3:0] data_bits(input logic [2:0] code);
    if (code == `CSZ_NINE) begin
      return `RX_BITS_NINE;
    end else if (code <= `CSZ_LAST_SHORT) begin
      return `RX_BITS_MIN + {1'b0, code};
    end else begin
      return `RX_BITS_EIGHT;
    end
  endfunction

  // bits arrive lsb first at the top, so short characters sit high
  function automatic logic [8:0] align_data(input logic [8:0] sh, input logic [3:0] n);
    return sh >> (`RX_BITS_NINE - n);
  endfunction

endpackage

// >>> design/baud_tick_gen.sv
`timescale 1ns/1ps
`include "usart_rx_defs.svh"

module baud_tick_gen #(
  parameter int DIV_W = `RX_DIV_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  import usart_rx_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_s;

  div_s q;
  div_s next_q;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("baud_tick_gen: DIV_W must be 1..16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // one pulse every divisor+1 cycles; restarts when stopped
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.tick = 1'b0;
    if (!run) begin
      next_q.cnt = '0;
    end else if (q.cnt == '0) begin
      next_q.cnt  = divisor;
      next_q.tick = 1'b1;
    end else begin
      next_q.cnt = q.cnt - DIV_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;

endmodule

// >>> design/rx_fifo2.sv
`timescale 1ns/1ps
`include "usart_rx_defs.svh"

module rx_fifo2 #(
  parameter int WIDTH = `ENT_W,
  parameter int DEPTH = `RX_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import usart_rx_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [CW-1:0]               count;
  } fifo_s;

  fifo_s         q;
  fifo_s         next_q;
  logic          push;
  logic          pop;
  logic [CW-1:0] wr_idx;

  generate
    if (DEPTH != 2 || WIDTH < 1) begin : g_bad_shape
      $error("rx_fifo2: DEPTH must be 2 and WIDTH positive");
    end
  endgenerate

  // ----------------------------------------------------------------
  // slot 0 is always the head, so reads shift the rest down
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    push   = in_valid && in_ready;
    pop    = out_ready && out_valid;
    wr_idx = q.count - CW'(pop);
    if (flush) begin
      next_q.count = '0;
    end else begin
      if (pop) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          next_q.slot[i] = q.slot[i+1];
        end
      end
      if (push) begin
        next_q.slot[wr_idx] = in_data;
      end
      next_q.count = q.count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign in_ready  = q.count < CW'(DEPTH);
  assign out_valid = q.count != '0;
  assign out_data  = q.slot[0];

endmodule

// >>> design/usart_receive_buffer_flags.sv
`timescale 1ns/1ps
`include "usart_rx_defs.svh"

module usart_receive_buffer_flags #(
  parameter int DIV_W = `RX_DIV_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             rxd_pin,
  input  wire logic [DIV_W-1:0] baud_div,
  input  wire logic             receiver_enable,
  input  wire logic [2:0]       char_size_sel,
  input  wire logic             parity_enable_bit,
  input  wire logic             parity_odd_sel,
  input  wire logic             rx_complete_irq_en,
  input  wire logic             global_irq_en,
  input  wire logic             data_rd,
  output logic [7:0]            serial_data_reg,
  output logic                  rx_ninth_bit,
  output logic                  frame_err_flag,
  output logic                  overrun_flag,
  output logic                  parity_err_flag,
  output logic                  rx_complete,
  output logic                  rx_complete_irq,
  output logic                  rxd_override
);
  import usart_rx_pkg::*;

  // ----------------------------------------------------------------
  // state and internal wires
  // ----------------------------------------------------------------
  rx_top_s           q;
  rx_top_s           next_q;

  logic              baud_tick;
  logic              fifo_in_ready;
  logic [`ENT_W-1:0] fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_pop;
  logic [`ENT_W-1:0] fifo_out_data;

  logic              sample;
  logic [3:0]        cnt_next;
  logic              decide;
  logic              bit_val;
  logic [8:0]        shifted;
  logic [8:0]        aligned;
  logic              upe_bit;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
      $error("usart_receive_buffer_flags: DIV_W must be 1..16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // sample-rate enable, sixteen ticks per bit
  // ----------------------------------------------------------------
  baud_tick_gen #(
    .DIV_W   (DIV_W)
  ) u_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .run     (receiver_enable),
    .divisor (baud_div),
    .tick    (baud_tick)
  );

  // ----------------------------------------------------------------
  // two-character receive buffer
  // ----------------------------------------------------------------
  // overrun joins frame at transfer
  assign fifo_in_data = {q.lost, q.pend_entry[`ENT_UPE:0]};

  assign fifo_pop = data_rd && receiver_enable;

  rx_fifo2 #(
    .WIDTH     (`ENT_W),
    .DEPTH     (`RX_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .flush     (!receiver_enable),
    .in_valid  (q.frame_pending),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // receive sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_q   = q;
    sample   = q.rxd_sync;
    cnt_next = q.tick_cnt + `RX_TICK_ONE;
    decide   = baud_tick && (q.state != ST_IDLE) && (cnt_next == `RX_VOTE_LAST);
    bit_val  = majority3({q.votes[1:0], sample});
    shifted  = {bit_val, q.shreg[8:1]};
    aligned  = align_data(q.shreg, data_bits(char_size_sel));
    upe_bit  = parity_enable_bit && q.par_err;

    // first flop feeds only the second
    next_q.rxd_meta = rxd_pin;
    next_q.rxd_sync = q.rxd_meta;

    // waiting frame moves as soon as a slot is free
    if (q.frame_pending && fifo_in_ready) begin
      next_q.frame_pending = 1'b0;
      next_q.lost = 1'b0;
    end

    if (baud_tick && q.state != ST_IDLE) begin
      next_q.tick_cnt = cnt_next;
      if (cnt_next >= `RX_VOTE_FIRST && cnt_next <= `RX_VOTE_LAST) begin
        next_q.votes = {q.votes[1:0], sample};
      end
    end

    case (q.state)
      ST_IDLE: begin
        if (baud_tick && !sample) begin
          next_q.state    = ST_START;
          next_q.tick_cnt = `RX_START_CNT;
          next_q.votes    = '0;
        end
      end
      ST_START: begin
        if (decide) begin
          if (bit_val) begin
            // noise spike, look for the next falling edge
            next_q.state = ST_IDLE;
          end else begin
            next_q.state     = ST_DATA;
            next_q.bits_left = data_bits(char_size_sel);
            next_q.shreg     = '0;
            next_q.par_acc   = 1'b0;
            next_q.par_err   = 1'b0;
            if (q.frame_pending && !fifo_in_ready) begin
              next_q.frame_pending = 1'b0;
              next_q.lost          = 1'b1;
            end
          end
        end
      end
      ST_DATA: begin
        if (decide) begin
          next_q.shreg     = shifted;
          next_q.par_acc   = q.par_acc ^ bit_val;
          next_q.bits_left = q.bits_left - `RX_TICK_ONE;
          if (q.bits_left == `RX_BITS_LAST) begin
            next_q.state = parity_enable_bit ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY: begin
        if (decide) begin
          // even when zero, odd when one
          next_q.par_err = q.par_acc ^ bit_val ^ parity_odd_sel;
          next_q.state   = ST_STOP;
        end
      end
      ST_STOP: begin
        if (decide) begin
          next_q.state         = ST_IDLE;
          next_q.frame_pending = 1'b1;
          // voted stop bit, low is error
          next_q.pend_entry    = {1'b0, upe_bit, !bit_val, aligned};
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase

    if (!receiver_enable) begin
      next_q.state         = ST_IDLE;
      next_q.frame_pending = 1'b0;
      next_q.lost          = 1'b0;
      next_q.tick_cnt      = '0;
    end

    // ----------------------------------------------------------------
    // visible flags follow the buffer head, one cycle behind it
    // ----------------------------------------------------------------
    // head frame's data, ninth bit and error flags
    next_q.data_out  = fifo_out_data[`ENT_DATA_MSB:0];
    next_q.ninth_out = fifo_out_data[`ENT_NINTH];
    next_q.fe_out    = fifo_out_data[`ENT_FE];
    next_q.dor_out   = fifo_out_data[`ENT_DOR];
    next_q.upe_out   = fifo_out_data[`ENT_UPE] && parity_enable_bit;
    next_q.rxc_out   = fifo_out_valid && receiver_enable;
    next_q.irq_out   = fifo_out_valid && receiver_enable && rx_complete_irq_en && global_irq_en;
    next_q.override_out = receiver_enable;

    // empty or disabled buffer shows zeros, never a flushed entry
    if (!(fifo_out_valid && receiver_enable)) begin
      next_q.data_out  = '0;
      next_q.ninth_out = 1'b0;
      next_q.fe_out    = 1'b0;
      next_q.dor_out   = 1'b0;
      next_q.upe_out   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.rxd_meta <= `RX_LINE_IDLE;
      q.rxd_sync <= `RX_LINE_IDLE;
      q.state    <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign serial_data_reg = q.data_out;
  assign rx_ninth_bit    = q.ninth_out;
  assign frame_err_flag  = q.fe_out;
  assign overrun_flag    = q.dor_out;
  assign parity_err_flag = q.upe_out;
  assign rx_complete     = q.rxc_out;
  assign rx_complete_irq = q.irq_out;
  assign rxd_override    = q.override_out;

endmodule

// >>> verif/usart_rx_chk.sv
`timescale 1ns/1ps

module usart_rx_chk #(
  parameter int DIV_W = 12
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             rxd_pin,
  input wire logic [DIV_W-1:0] baud_div,
  input wire logic             receiver_enable,
  input wire logic [2:0]       char_size_sel,
  input wire logic             parity_enable_bit,
  input wire logic             parity_odd_sel,
  input wire logic             rx_complete_irq_en,
  input wire logic             global_irq_en,
  input wire logic             data_rd,
  input wire logic [7:0]       serial_data_reg,
  input wire logic             rx_ninth_bit,
  input wire logic             frame_err_flag,
  input wire logic             overrun_flag,
  input wire logic             parity_err_flag,
  input wire logic             rx_complete,
  input wire logic             rx_complete_irq,
  input wire logic             rxd_override
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // --------------------
  // sequences
  // --------------------
  sequence s_off;
    !receiver_enable ##1 !receiver_enable;
  endsequence
  // no pop and no disable that could still reach the outputs
  sequence s_quiet;
    receiver_enable && !data_rd ##1 receiver_enable && !data_rd && rx_complete;
  endsequence

  // --------------------
  // assertions
  // --------------------
  irq_set_a: assert property (rx_complete && $past(rx_complete_irq_en && global_irq_en) |-> rx_complete_irq)
    else $error("receive interrupt missing while complete and enabled");
  irq_gate_a: assert property (rx_complete_irq |-> rx_complete && $past(rx_complete_irq_en && global_irq_en))
    else $error("receive interrupt without complete flag or enables");
  disable_flush_a: assert property (s_off |-> !rx_complete && !rx_complete_irq)
    else $error("complete flag survives receiver disable");
  empty_zero_a: assert property (!rx_complete |->
    {serial_data_reg, rx_ninth_bit, frame_err_flag, overrun_flag, parity_err_flag} == 12'h000)
    else $error("head data or flags not zero while empty");
  upe_off_a: assert property ($past(!parity_enable_bit) |-> !parity_err_flag)
    else $error("parity error shown while checking is off");
  pin_owner_a: assert property (rxd_override == $past(receiver_enable && rst_n))
    else $error("pin override does not follow receiver enable");
  rxc_fall_a: assert property ($fell(rx_complete) |-> $past(data_rd, 2) || !$past(receiver_enable))
    else $error("complete flag dropped without read or disable");
  head_hold_a: assert property (s_quiet ##1 rx_complete |->
    $stable({serial_data_reg, rx_ninth_bit, frame_err_flag, overrun_flag}))
    else $error("head entry changed without a read");
endmodule

bind usart_receive_buffer_flags usart_rx_chk #(.DIV_W(DIV_W)) usart_rx_chk_i (.mclk, .rst_n, .rxd_pin,
  .baud_div, .receiver_enable, .char_size_sel, .parity_enable_bit, .parity_odd_sel, .rx_complete_irq_en,
  .global_irq_en, .data_rd, .serial_data_reg, .rx_ninth_bit, .frame_err_flag, .overrun_flag,
  .parity_err_flag, .rx_complete, .rx_complete_irq, .rxd_override);

// >>> verif/serial_tx_model.sv
`timescale 1ns/1ps

module serial_tx_model #(
  parameter int BIT = 32
) (
  input wire logic mclk,
  output logic     rxd
);
  // idle line level is high between frames
  initial rxd = 1'b1;

  task automatic bitv(input logic v);
    rxd = v;
    repeat (BIT) @(negedge mclk);
  endtask

  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic pbit,
                      input logic stopv, input int stops);
    @(negedge mclk);
    // start, data lsb first, parity, then stop
    bitv(1'b0);
    for (int i = 0; i < n; i++) bitv(d[i]);
    if (pen) bitv(pbit);
    bitv(stopv);
    // extra stop bit the receiver must ignore
    if (stops > 1) bitv(1'b1);
    rxd = 1'b1;
  endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import usart_rx_pkg::*;

  localparam int BIT = 32;

  logic        mclk = 1'b0;
  logic        rst_n, rxd_pin, receiver_enable, parity_enable_bit, parity_odd_sel;
  logic        rx_complete_irq_en, global_irq_en, data_rd;
  logic [11:0] baud_div;
  logic [2:0]  char_size_sel;
  logic [7:0]  serial_data_reg;
  logic        rx_ninth_bit, frame_err_flag, overrun_flag, parity_err_flag;
  logic        rx_complete, rx_complete_irq, rxd_override;
  int          errors = 0;
  int          n_compared = 0;
  int          i;

  always #2.5 mclk = ~mclk;

  usart_receive_buffer_flags usart_receive_buffer_flags_i (.mclk, .rst_n, .rxd_pin, .baud_div,
    .receiver_enable, .char_size_sel, .parity_enable_bit, .parity_odd_sel, .rx_complete_irq_en,
    .global_irq_en, .data_rd, .serial_data_reg, .rx_ninth_bit, .frame_err_flag, .overrun_flag,
    .parity_err_flag, .rx_complete, .rx_complete_irq, .rxd_override);

  serial_tx_model #(.BIT(BIT)) serial_tx_model_i (.mclk, .rxd(rxd_pin));

  // --------------------
  // tasks
  // --------------------
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // expected is {complete, ninth, frame, overrun, parity, data}
  task automatic head(input logic [12:0] e);
    chk("head", e, {rx_complete, rx_ninth_bit, frame_err_flag, overrun_flag, parity_err_flag, serial_data_reg});
  endtask

  task automatic rd;
    data_rd = 1'b1;
    @(negedge mclk);
    data_rd = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic wait_rxc;
    int k;
    for (k = 0; k < 30 * BIT && rx_complete !== 1'b1; k++) @(negedge mclk);
    if (k == 30 * BIT) begin
      chk("rx_complete", 13'h1, {12'h000, rx_complete});
      end_sim;
    end
  endtask

  task automatic snd(input logic [8:0] d, input int n, input logic bad, input logic stopv, input int stops);
    logic p;
    // even parity bit equals xor of data; odd inverts it
    p = ^(d & ((9'h001 << n) - 9'h001)) ^ parity_odd_sel ^ bad;
    serial_tx_model_i.send(d, n, parity_enable_bit, p, stopv, stops);
  endtask

  // --------------------
  // main sequence
  // --------------------
  initial begin
    // no status writes, so the error bits are never written
    rst_n = 1'b0;
    data_rd = 1'b0;
    baud_div = 12'h001;
    receiver_enable = 1'b1;
    char_size_sel = 3'h3;
    parity_enable_bit = 1'b0;
    parity_odd_sel = 1'b0;
    rx_complete_irq_en = 1'b1;
    global_irq_en = 1'b1;
    repeat (3) @(negedge mclk);
    head(13'h0000);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    snd(9'h0A5, 8, 1'b0, 1'b1, 1);
    wait_rxc;
    head({5'h10, 8'hA5});
    chk("irq", 13'h1, {12'h000, rx_complete_irq});
    global_irq_en = 1'b0;
    repeat (2) @(negedge mclk);
    chk("irq", 13'h0, {12'h000, rx_complete_irq});
    global_irq_en = 1'b1;
    rd;
    head(13'h0000);
    rd;
    head(13'h0000);
    // four frames unread: third is lost at the start of the fourth
    for (i = 1; i < 5; i++) snd(9'h011 * 9'(i), 8, 1'b0, 1'b1, 1);
    repeat (BIT) @(negedge mclk);
    head({5'h10, 8'h11});
    rd;
    head({5'h10, 8'h22});
    rd;
    head({5'h12, 8'h44});
    rd;
    head(13'h0000);
    snd(9'h055, 8, 1'b0, 1'b1, 1);
    wait_rxc;
    head({5'h10, 8'h55});
    rd;
    char_size_sel = 3'h7;
    snd(9'h1C3, 9, 1'b0, 1'b1, 2);
    snd(9'h0F0, 9, 1'b0, 1'b0, 1);
    head({5'h18, 8'hC3});
    rd;
    head({5'h14, 8'hF0});
    rd;
    char_size_sel = 3'h0;
    parity_enable_bit = 1'b1;
    for (i = 0; i < 4; i++) begin
      parity_odd_sel = i[0];
      snd(9'h1F5, 5, i[1], 1'b1, 1);
      wait_rxc;
      head({4'h8, i[1], 8'h15});
      if (i < 3) rd;
    end
    parity_enable_bit = 1'b0;
    repeat (2) @(negedge mclk);
    chk("parity", 13'h0, {12'h000, parity_err_flag});
    rd;
    // reserved size code must act as eight bits
    char_size_sel = 3'h5;
    snd(9'h081, 8, 1'b0, 1'b1, 1);
    snd(9'h082, 8, 1'b0, 1'b1, 1);
    for (i = 0; i < 4 && rx_complete === 1'b1; i++) rd;
    chk("reads", 13'h2, 13'(i));
    snd(9'h066, 8, 1'b0, 1'b1, 1);
    snd(9'h077, 8, 1'b0, 1'b1, 1);
    head({5'h10, 8'h66});
    receiver_enable = 1'b0;
    repeat (2) @(negedge mclk);
    head(13'h0000);
    chk("override", 13'h0, {12'h000, rxd_override});
    receiver_enable = 1'b1;
    repeat (2) @(negedge mclk);
    chk("override", 13'h1, {12'h000, rxd_override});
    snd(9'h099, 8, 1'b0, 1'b1, 1);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    head(13'h0000);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    end_sim;
  end
endmodule
